// >>> tb/ccu_clock_config_bench.sv
// self-checking bench for the upper clock configuration fields
`timescale 1ns/1ps
`default_nettype none
module ccu_clock_config_bench;
    logic                           i_clk;
    logic                           i_reset;
    logic                           i_wr;
    logic                           i_rd;
    logic                           i_pll_enabled;
    logic                           i_usb_clock_enabled;
    logic [ccu_pkg::CCU_ADDR_W-1:0] i_addr;
    logic [31:0]                    i_wdata;
    logic [31:0]                    o_rdata;
    logic [3:0]                     o_pll_multiplier;
    logic [3:0]                     src;
    logic [3:0]                     src_d;
    logic [3:0]                     cnt = 4'h0;
    logic [4:0]                     o_pll_factor;
    logic [2:0]                     o_usb_half_divider;
    logic [2:0]                     o_sdram_divider;
    logic [2:0]                     o_clock_out_select;
    logic [1:0]                     o_fpu_divider;
    logic                           o_clock_output_pin;
    logic                           prev;
    logic [2:0]                     uh [4] = '{3'h3, 3'h2, 3'h4, 3'h5};
    int                             miscompares = 0;
    int                             n_checks = 0;
    int                             n;
    logic [3:0]                     c;
    logic                           pin_e;
    logic [2:0]                     sd [4] = '{3'h1, 3'h2, 3'h4, 3'h4};

    ccu_clock_config dut_u (
        .i_clk                (i_clk),
        .i_reset              (i_reset),
        .i_addr               (i_addr),
        .i_wdata              (i_wdata),
        .i_wr                 (i_wr),
        .i_rd                 (i_rd),
        .i_pll_enabled        (i_pll_enabled),
        .i_usb_clock_enabled  (i_usb_clock_enabled),
        .i_system_clock       (src[0]),
        .i_internal_rc_clock  (src[1]),
        .i_external_osc_clock (src[2]),
        .i_pll_output_clock   (src[3]),
        .o_rdata              (o_rdata),
        .o_pll_multiplier     (o_pll_multiplier),
        .o_pll_factor         (o_pll_factor),
        .o_usb_half_divider   (o_usb_half_divider),
        .o_fpu_divider        (o_fpu_divider),
        .o_sdram_divider      (o_sdram_divider),
        .o_clock_out_select   (o_clock_out_select),
        .o_clock_output_pin   (o_clock_output_pin)
    );

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // slow synchronous sources, pll one is rc inverted so the two differ
    always @(posedge i_clk) begin
        cnt   <= cnt + 4'h1;
        src   <= {~cnt[1], cnt[2], cnt[1], cnt[0]};
        src_d <= src;
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        // decoded outputs trail the field by one cycle
        repeat (2) @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        chk("rdata", e, o_rdata);
        @(posedge i_clk);
        #1;
        chk("rdata idle", 32'h0, o_rdata);
    endtask

    function automatic logic [31:0] mk(input logic [3:0] m,
        input logic [1:0] u, input logic [2:0] s, input logic f,
        input logic [1:0] d);
        return {2'h0, d, f, s, u, m, 18'h0};
    endfunction

    function automatic logic [31:0] xf(input logic [3:0] m);
        return (m > 4'hd) ? 32'h10 : {28'h0, m} + 32'h2;
    endfunction

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        miscompares++;
        final_report;
    end

    initial begin
        {i_reset, i_wr, i_rd, i_pll_enabled, i_usb_clock_enabled} = 5'h10;
        i_addr  = 8'h00;
        i_wdata = 32'h0;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h04, 32'h0);
        chk("factor", 32'h2, o_pll_factor);
        chk("usb", 32'h3, o_usb_half_divider);
        chk("fpu", 32'h1, o_fpu_divider);
        chk("sdram", 32'h1, o_sdram_divider);
        for (int k = 0; k < 16; k++) begin
            c = k[3:0];
            wr(8'h04, mk(c, c[1:0], 3'h0, c[0], c[1:0]));
            chk("mult", {28'h0, c}, o_pll_multiplier);
            chk("factor", xf(c), o_pll_factor);
            chk("usb", uh[c[1:0]], o_usb_half_divider);
            chk("fpu", c[0] ? 32'h2 : 32'h1, o_fpu_divider);
            chk("sdram", sd[c[1:0]], o_sdram_divider);
            rd(8'h04, mk(c, c[1:0], 3'h0, c[0], c[1:0]));
        end
        @(posedge i_clk);
        i_pll_enabled       <= 1'b1;
        i_usb_clock_enabled <= 1'b1;
        for (int s = 0; s < 7; s++) begin
            wr(8'h04, mk(4'h3, 2'h0, s[2:0], 1'b0, 2'h0));
            chk("frozen factor", 32'h10, o_pll_factor);
            chk("taken fpu", 32'h1, o_fpu_divider);
            chk("taken sdram", 32'h1, o_sdram_divider);
            chk("frozen usb", 32'h5, o_usb_half_divider);
            chk("select", s, o_clock_out_select);
            repeat (8) begin
                @(negedge i_clk);
                pin_e = s[2] ? src_d[s[1:0]] : 1'b0;
                chk("pin", pin_e, o_clock_output_pin);
            end
        end
        rd(8'h04, mk(4'hf, 2'h3, 3'h6, 1'b0, 2'h0));
        wr(8'h04, mk(4'hf, 2'h3, 3'h7, 1'b0, 2'h0));
        prev = o_clock_output_pin;
        n    = 0;
        // pll source has period four, so pll/2 toggles eight times in 32
        repeat (32) begin
            @(negedge i_clk);
            if (o_clock_output_pin !== prev)
                n++;
            prev = o_clock_output_pin;
        end
        chk("pll half toggles", 32'h8, n);
        @(posedge i_clk);
        i_pll_enabled       <= 1'b0;
        i_usb_clock_enabled <= 1'b0;
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h3ffc_0000);
        wr(8'h08, 32'h0);
        rd(8'h04, 32'h3ffc_0000);
        rd(8'h08, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire

// >>> verilog/ccu_clock_config.sv
// upper fields of the clock configuration register and derived selections
`default_nettype none
`timescale 1ns/1ps
// Function
// [RULE1] the pll multiplier field takes writes only while the pll is off.
// [RULE2] multiplier codes 0 to 13 give code plus two, codes 14 and 15 give 16.
// [RULE3] software keeps the pll output at or below its maximum frequency.
// [RULE4] the usb prescaler divides the pll output by 1.5, 1, 2 or 2.5.
// [RULE5] while a usb device clock is on, the usb prescaler cannot be changed.
// [RULE6] software sets the usb prescaler and checks it before usb clock on.
// [RULE7] the clock out select drives none, system, rc, oscillator or pll/2.
// [RULE8] the clock output pin may glitch when started or switched.
// [RULE9] software keeps the system clock on the pin at or below io limit.
// [RULE10] the fpu bit selects the ahb clock undivided or divided by two.
// [RULE11] the sdram prescaler divides by one, two or four.
// [RULE12] software keeps the sdram clock below its maximum frequency.
// [RULE13] fields change only through software writes.
// [RULE14] bits 31:30 read as zero and ignore writes.
module ccu_clock_config (
    input  wire logic                           i_clk,
    input  wire logic                           i_reset,
    input  wire logic [ccu_pkg::CCU_ADDR_W-1:0] i_addr,
    input  wire logic [31:0]                    i_wdata,
    input  wire logic                           i_wr,
    input  wire logic                           i_rd,
    input  wire logic                           i_pll_enabled,
    input  wire logic                           i_usb_clock_enabled,
    input  wire logic                           i_system_clock,
    input  wire logic                           i_internal_rc_clock,
    input  wire logic                           i_external_osc_clock,
    input  wire logic                           i_pll_output_clock,
    output logic      [31:0]                    o_rdata,
    output logic      [3:0]                     o_pll_multiplier,
    output logic      [4:0]                     o_pll_factor,
    output logic      [2:0]                     o_usb_half_divider,
    output logic      [1:0]                     o_fpu_divider,
    output logic      [2:0]                     o_sdram_divider,
    output logic      [2:0]                     o_clock_out_select,
    output logic                                o_clock_output_pin
);
    typedef ccu_pkg::ccu_clkout_e ccu_clkout_sel_t;

    logic                    cfg_hit;
    logic                    cfg_wr;
    logic [3:0]              pll_multiplier_r;
    logic [1:0]              usb_clock_prescaler_r;
    logic [2:0]              clock_out_select_r;
    logic                    fpu_clock_prescaler_r;
    logic [1:0]              sdram_clock_prescaler_r;
    logic [31:0]             cfg_value;
    logic [4:0]              pll_factor_nxt;
    logic [2:0]              usb_hdiv_nxt;
    logic [2:0]              sdram_div_nxt;
    logic                    pll_half_r;
    logic                    pll_clk_prev_r;
    logic                    pin_nxt;
    ccu_clkout_sel_t         sel_view;

    assign cfg_hit = (i_addr == ccu_pkg::CCU_CFG_OFFSET);
    assign cfg_wr  = i_wr && cfg_hit;

    // lower fields live elsewhere and read as zero here
    always_comb begin
        cfg_value = 32'h0000_0000;
        cfg_value[ccu_pkg::CCU_PLLMUL_MSB:ccu_pkg::CCU_PLLMUL_LSB] =
            pll_multiplier_r;
        cfg_value[ccu_pkg::CCU_USBPSC_MSB:ccu_pkg::CCU_USBPSC_LSB] =
            usb_clock_prescaler_r;
        cfg_value[ccu_pkg::CCU_CLKSEL_MSB:ccu_pkg::CCU_CLKSEL_LSB] =
            clock_out_select_r;
        cfg_value[ccu_pkg::CCU_FPU_CLOCK_PRESCALER_BIT] = fpu_clock_prescaler_r;
        cfg_value[ccu_pkg::CCU_SDPSC_MSB:ccu_pkg::CCU_SDPSC_LSB] =
            sdram_clock_prescaler_r;
    end

    // read data valid the cycle after the strobe only; unmapped reads zero
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd && cfg_hit) begin
            o_rdata <= cfg_value; // RULE14
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // multiplier is frozen while the pll runs, retuning it live would unlock
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pll_multiplier_r <= ccu_pkg::CCU_PLLMUL_RST;
        end else if (cfg_wr && !i_pll_enabled) begin // RULE1 RULE13
            pll_multiplier_r <=
                i_wdata[ccu_pkg::CCU_PLLMUL_MSB:ccu_pkg::CCU_PLLMUL_LSB];
        end
    end

    // held whole while a usb clock runs, so a running usb clock never shifts
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            usb_clock_prescaler_r <= ccu_pkg::CCU_USBPSC_RST;
        end else if (cfg_wr && !i_usb_clock_enabled) begin // RULE5 RULE13
            usb_clock_prescaler_r <=
                i_wdata[ccu_pkg::CCU_USBPSC_MSB:ccu_pkg::CCU_USBPSC_LSB];
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            clock_out_select_r      <= ccu_pkg::CCU_CLKSEL_RST;
            fpu_clock_prescaler_r   <= ccu_pkg::CCU_FPU_CLOCK_PRESCALER_RST;
            sdram_clock_prescaler_r <= ccu_pkg::CCU_SDPSC_RST;
        end else if (cfg_wr) begin // RULE13
            clock_out_select_r      <=
                i_wdata[ccu_pkg::CCU_CLKSEL_MSB:ccu_pkg::CCU_CLKSEL_LSB];
            fpu_clock_prescaler_r   <= i_wdata[ccu_pkg::CCU_FPU_CLOCK_PRESCALER_BIT];
            sdram_clock_prescaler_r <=
                i_wdata[ccu_pkg::CCU_SDPSC_MSB:ccu_pkg::CCU_SDPSC_LSB];
        end
    end

    // decode of the stored codes
    always_comb begin
        if (pll_multiplier_r > ccu_pkg::CCU_PLLMUL_LAST) begin
            pll_factor_nxt = ccu_pkg::CCU_PLLMUL_CAP; // RULE2
        end else begin
            pll_factor_nxt = ccu_pkg::CCU_PLLMUL_BASE
                + {1'b0, pll_multiplier_r}; // RULE2
        end
        case (usb_clock_prescaler_r) // RULE4
            2'h0:    usb_hdiv_nxt = ccu_pkg::CCU_USB_HDIV_0;
            2'h1:    usb_hdiv_nxt = ccu_pkg::CCU_USB_HDIV_1;
            2'h2:    usb_hdiv_nxt = ccu_pkg::CCU_USB_HDIV_2;
            default: usb_hdiv_nxt = ccu_pkg::CCU_USB_HDIV_3;
        endcase
        case (sdram_clock_prescaler_r) // RULE11
            ccu_pkg::CCU_SDPSC_RST:    sdram_div_nxt = ccu_pkg::CCU_SD_DIV_1;
            ccu_pkg::CCU_SD_CODE_DIV2: sdram_div_nxt = ccu_pkg::CCU_SD_DIV_2;
            default:                   sdram_div_nxt = ccu_pkg::CCU_SD_DIV_4;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pll_multiplier   <= ccu_pkg::CCU_PLLMUL_RST;
            o_pll_factor       <= ccu_pkg::CCU_PLLMUL_BASE;
            o_usb_half_divider <= ccu_pkg::CCU_USB_HDIV_0;
            o_fpu_divider      <= ccu_pkg::CCU_FPU_DIV_1;
            o_sdram_divider    <= ccu_pkg::CCU_SD_DIV_1;
            o_clock_out_select <= ccu_pkg::CCU_CLKSEL_RST;
        end else begin
            o_pll_multiplier   <= pll_multiplier_r;
            o_pll_factor       <= pll_factor_nxt;
            o_usb_half_divider <= usb_hdiv_nxt;
            o_fpu_divider      <= fpu_clock_prescaler_r ? // RULE10
                ccu_pkg::CCU_FPU_DIV_2 : ccu_pkg::CCU_FPU_DIV_1;
            o_sdram_divider    <= sdram_div_nxt;
            o_clock_out_select <= clock_out_select_r;
        end
    end

    // pll halved by toggling on each sampled rising edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pll_clk_prev_r <= 1'b0;
            pll_half_r     <= 1'b0;
        end else begin
            pll_clk_prev_r <= i_pll_output_clock;
            if (i_pll_output_clock && !pll_clk_prev_r) begin
                pll_half_r <= !pll_half_r;
            end
        end
    end

    assign sel_view = ccu_clkout_sel_t'(clock_out_select_r);

    // plain mux, no glitch guard: a short pulse on a switch is tolerated
    always_comb begin
        case (sel_view) // RULE7 RULE8
            ccu_pkg::CCU_OUT_SYS:  pin_nxt = i_system_clock;
            ccu_pkg::CCU_OUT_RC:   pin_nxt = i_internal_rc_clock;
            ccu_pkg::CCU_OUT_EXT:  pin_nxt = i_external_osc_clock;
            ccu_pkg::CCU_OUT_PLL2: pin_nxt = pll_half_r;
            default:               pin_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_clock_output_pin <= 1'b0;
        end else begin
            o_clock_output_pin <= pin_nxt; // RULE7
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_mul_write_off;
        cfg_wr && !i_pll_enabled;
    endsequence

    sequence s_mul_reaches_out;
        ##2 o_pll_multiplier == $past(i_wdata[21:18], 2);
    endsequence

    a_pllmul_locked: assert property ( // RULE1
        cfg_wr && i_pll_enabled |=> $stable(pll_multiplier_r))
        else $error("pll multiplier changed while pll running");

    a_pllmul_write: assert property ( // RULE1
        s_mul_write_off |-> s_mul_reaches_out)
        else $error("pll multiplier write did not take");

    a_pll_factor: assert property ( // RULE2
        ##1 o_pll_factor == (($past(pll_multiplier_r) > 4'hd) ? 5'h10 :
            5'h02 + {1'b0, $past(pll_multiplier_r)}))
        else $error("pll factor decode wrong");

    a_usb_hold: assert property ( // RULE5
        i_usb_clock_enabled |=> $stable(usb_clock_prescaler_r))
        else $error("usb prescaler changed while usb clock on");

    a_usb_divider: assert property ( // RULE4
        cfg_wr && !i_usb_clock_enabled && i_wdata[23:22] == 2'h3
        |-> ##2 o_usb_half_divider == 3'h5)
        else $error("usb divider for code three wrong");

    a_fpu_divider: assert property ( // RULE10
        cfg_wr |-> ##2 o_fpu_divider == ($past(i_wdata[27], 2) ? 2'h2 : 2'h1))
        else $error("fpu divider not following write");

    a_sdram_divider: assert property ( // RULE11
        cfg_wr && i_wdata[29:28] == 2'h2 |-> ##2 o_sdram_divider == 3'h4)
        else $error("sdram divider for code two wrong");

    a_no_spontaneous: assert property ( // RULE13
        !cfg_wr |=> $stable(cfg_value))
        else $error("configuration changed without a write");

    a_reserved_zero: assert property ( // RULE14
        i_rd |=> o_rdata[31:30] == 2'h0 && o_rdata[17:0] == 18'h0)
        else $error("reserved or foreign bits read non zero");

    a_pin_off: assert property ( // RULE7
        !clock_out_select_r[2] |=> !o_clock_output_pin)
        else $error("clock pin active while output disabled");

    a_pin_sys: assert property ( // RULE7
        sel_view == ccu_pkg::CCU_OUT_SYS |=>
            o_clock_output_pin == $past(i_system_clock))
        else $error("clock pin not following system clock");

    a_pin_rc: assert property ( // RULE7
        sel_view == ccu_pkg::CCU_OUT_RC |=>
            o_clock_output_pin == $past(i_internal_rc_clock))
        else $error("clock pin not following rc clock");

    a_pin_ext: assert property ( // RULE7
        sel_view == ccu_pkg::CCU_OUT_EXT |=>
            o_clock_output_pin == $past(i_external_osc_clock))
        else $error("clock pin not following oscillator clock");

    // halved clock flips once per sampled pll rising edge, else holds
    sequence s_pll_rise;
        i_pll_output_clock && !pll_clk_prev_r;
    endsequence

    a_half_toggle: assert property ( // RULE7
        s_pll_rise |=> pll_half_r != $past(pll_half_r))
        else $error("halved pll clock missed an edge");

    a_half_hold: assert property ( // RULE7
        !(i_pll_output_clock && !pll_clk_prev_r) |=> $stable(pll_half_r))
        else $error("halved pll clock moved without an edge");

    a_rdata_idle: assert property ( // RULE14
        !(i_rd && cfg_hit) |=> o_rdata == 32'h0000_0000)
        else $error("read data not zero outside a read");

    a_usb_write: assert property ( // RULE5
        cfg_wr && !i_usb_clock_enabled |=>
            usb_clock_prescaler_r == $past(i_wdata[23:22]))
        else $error("usb prescaler write did not take");

    // divider codes checked one by one through the write that sets them
    a_usb_code0: assert property ( // RULE4
        cfg_wr && !i_usb_clock_enabled && i_wdata[23:22] == 2'h0
        |-> ##2 o_usb_half_divider == 3'h3)
        else $error("usb divider for code zero wrong");

    a_usb_code1: assert property ( // RULE4
        cfg_wr && !i_usb_clock_enabled && i_wdata[23:22] == 2'h1
        |-> ##2 o_usb_half_divider == 3'h2)
        else $error("usb divider for code one wrong");

    a_usb_code2: assert property ( // RULE4
        cfg_wr && !i_usb_clock_enabled && i_wdata[23:22] == 2'h2
        |-> ##2 o_usb_half_divider == 3'h4)
        else $error("usb divider for code two wrong");

    a_sdram_undivided: assert property ( // RULE11
        cfg_wr && i_wdata[29:28] == 2'h0 |-> ##2 o_sdram_divider == 3'h1)
        else $error("sdram divider for code zero wrong");

    a_sdram_halved: assert property ( // RULE11
        cfg_wr && i_wdata[29:28] == 2'h1 |-> ##2 o_sdram_divider == 3'h2)
        else $error("sdram divider for code one wrong");

    a_sdram_code3: assert property ( // RULE11
        cfg_wr && i_wdata[29:28] == 2'h3 |-> ##2 o_sdram_divider == 3'h4)
        else $error("sdram divider for code three wrong");

    a_select_out: assert property ( // RULE7
        cfg_wr |-> ##2 o_clock_out_select == $past(i_wdata[26:24], 2))
        else $error("clock out select not following write");
endmodule
`default_nettype wire

// >>> verilog/ccu_pkg.sv
// constants for the upper clock configuration fields
`default_nettype none
package ccu_pkg;
    localparam int          CCU_ADDR_W       = 8;
    localparam logic [7:0]  CCU_CFG_OFFSET   = 8'h04;
    localparam logic [31:0] CCU_CFG_RESET    = 32'h0000_0000;
    // field positions
    localparam int          CCU_PLLMUL_LSB   = 18;
    localparam int          CCU_PLLMUL_MSB   = 21;
    localparam int          CCU_USBPSC_LSB   = 22;
    localparam int          CCU_USBPSC_MSB   = 23;
    localparam int          CCU_CLKSEL_LSB   = 24;
    localparam int          CCU_CLKSEL_MSB   = 26;
    localparam int          CCU_FPU_CLOCK_PRESCALER_BIT   = 27;
    localparam int          CCU_SDPSC_LSB    = 28;
    localparam int          CCU_SDPSC_MSB    = 29;
    // field reset values
    localparam logic [3:0]  CCU_PLLMUL_RST   = 4'h0;
    localparam logic [1:0]  CCU_USBPSC_RST   = 2'h0;
    localparam logic [2:0]  CCU_CLKSEL_RST   = 3'h0;
    localparam logic        CCU_FPU_CLOCK_PRESCALER_RST   = 1'b0;
    localparam logic [1:0]  CCU_SDPSC_RST    = 2'h0;
    // pll multiplier decode
    localparam logic [3:0]  CCU_PLLMUL_LAST  = 4'hd;
    localparam logic [4:0]  CCU_PLLMUL_BASE  = 5'h02;
    localparam logic [4:0]  CCU_PLLMUL_CAP   = 5'h10;
    // usb divider, expressed in half steps (ratio times two)
    localparam logic [2:0]  CCU_USB_HDIV_0   = 3'h3;
    localparam logic [2:0]  CCU_USB_HDIV_1   = 3'h2;
    localparam logic [2:0]  CCU_USB_HDIV_2   = 3'h4;
    localparam logic [2:0]  CCU_USB_HDIV_3   = 3'h5;
    // fpu and sdram dividers
    localparam logic [1:0]  CCU_FPU_DIV_1    = 2'h1;
    localparam logic [1:0]  CCU_FPU_DIV_2    = 2'h2;
    localparam logic [2:0]  CCU_SD_DIV_1     = 3'h1;
    localparam logic [2:0]  CCU_SD_DIV_2     = 3'h2;
    localparam logic [2:0]  CCU_SD_DIV_4     = 3'h4;
    localparam logic [1:0]  CCU_SD_CODE_DIV2 = 2'h1;

    typedef enum logic [2:0] {
        CCU_OUT_NONE = 3'b000,
        CCU_OUT_SYS  = 3'b100,
        CCU_OUT_RC   = 3'b101,
        CCU_OUT_EXT  = 3'b110,
        CCU_OUT_PLL2 = 3'b111
    } ccu_clkout_e;
endpackage
`default_nettype wire
